/* arp_pkg.sv */
// constants for the converter result post-processing block
`default_nettype none

package arp_pkg;

	// ==========================================================
	// register map, byte addresses
	// ==========================================================
	localparam logic [31:0] ADDR_EXT_CONFIG    = 32'hffff0518; // extended configuration
	localparam logic [31:0] ADDR_COUNT_LIMIT   = 32'hffff0534; // result count limit
	localparam logic [31:0] ADDR_COUNT_VALUE   = 32'hffff0538; // result count value, ro
	localparam logic [31:0] ADDR_THRESHOLD     = 32'hffff053c; // comparator threshold
	localparam logic [31:0] ADDR_TH_CNT_LIMIT  = 32'hffff0540; // threshold count limit
	localparam logic [31:0] ADDR_TH_CNT_VALUE  = 32'hffff0544; // threshold count value, ro
	localparam logic [31:0] ADDR_ACCUMULATOR   = 32'hffff0548; // accumulator, ro
	localparam logic [31:0] ADDR_STATUS        = 32'hffff054c; // status flags, write 1 clears
	localparam logic [31:0] ADDR_MASK          = 32'hffff0550; // interrupt mask

	// ==========================================================
	// field positions in the extended configuration register
	// ==========================================================
	localparam int CFG_RES_CNT_EN  = 0; // result counter enable
	localparam int CFG_GND_RES     = 1; // series resistor select
	localparam int CFG_OVR_EN      = 2; // overrange enable
	localparam int CFG_CMP_LO      = 3; // comparator mode, low bit
	localparam int CFG_ACC_LO      = 5; // accumulator mode, low bit
	localparam int CFG_GND_EN      = 7; // ground switch enable

	// status and mask bit positions
	localparam int STA_THRESHOLD   = 3; // comparator threshold reached
	localparam int STA_OVERRANGE   = 4; // overrange seen
	localparam int MSK_COMPARE     = 6; // comparator interrupt mask

	// ==========================================================
	// reset values
	// ==========================================================
	localparam logic [7:0]  RST_EXT_CONFIG  = 8'h00;
	localparam logic [15:0] RST_COUNT_LIMIT = 16'h0001;
	localparam logic [15:0] RST_THRESHOLD   = 16'h0000;
	localparam logic [7:0]  RST_TH_LIMIT    = 8'h01;
	localparam logic [7:0]  RST_MASK        = 8'h00;

	// ==========================================================
	// mode encodings
	// ==========================================================
	typedef enum logic [1:0] {
		ARP_ACC_OFF     = 2'h0, // held at zero
		ARP_ACC_CLAMP   = 2'h1, // floor at zero
		ARP_ACC_FREE    = 2'h2, // may go negative
		ARP_ACC_CMP     = 2'h3  // accumulate plus comparator
	} arp_acc_mode_t;

	typedef enum logic [1:0] {
		ARP_CMP_OFF     = 2'h0, // comparator idle
		ARP_CMP_PLAIN   = 2'h1, // every result checked
		ARP_CMP_RESET   = 2'h2, // count, below resets
		ARP_CMP_DECR    = 2'h3  // count, below decrements
	} arp_cmp_mode_t;

	// ==========================================================
	// timing
	// ==========================================================
	localparam int CLK_PERIOD_NS   = 10;     // ref_clk period
	localparam int OVR_PERSIST_NS  = 125000; // 125 us overrange persistence
	// least time, so round up
	localparam int OVR_PERSIST_CYC = (OVR_PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : arp_pkg

`default_nettype wire

/* arp_threshold.sv */
// absolute-value threshold comparator with counting modes
`default_nettype none

module arp_threshold (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        result_valid,   // one-cycle result strobe
	input  wire logic        at_or_above,    // |result| >= threshold
	input  wire logic [1:0]  cmp_mode,       // effective comparator mode
	input  wire logic [7:0]  count_limit,    // threshold count limit
	output logic      [7:0]  count_value,    // threshold count value
	output logic             cmp_event       // one-cycle hit pulse
);

	// ==========================================================
	// state
	// ==========================================================
	logic [7:0] cnt_ff;     // threshold count value
	logic [7:0] nxt_cnt;
	logic       hit_ff;     // registered event
	logic       nxt_hit;

	// ==========================================================
	// next-state logic
	// ==========================================================
	// in the counting modes the counter only moves on a result strobe; idle clears it at once
	always_comb begin
		nxt_cnt = cnt_ff;
		nxt_hit = 1'b0;
		case (arp_pkg::arp_cmp_mode_t'(cmp_mode))
			arp_pkg::ARP_CMP_OFF: begin
				nxt_cnt = 8'h00; // idle keeps count clear
			end
			arp_pkg::ARP_CMP_PLAIN: begin
				nxt_hit = result_valid & at_or_above;
			end
			arp_pkg::ARP_CMP_RESET: begin
				if (result_valid) begin
					if (at_or_above) begin
						// saturate so a long run cannot wrap back to zero
						if (cnt_ff != 8'hff) nxt_cnt = cnt_ff + 8'h01;
					end else begin
						nxt_cnt = 8'h00;
					end
					// flag as soon as count equals limit
					nxt_hit = at_or_above && (nxt_cnt == count_limit);
				end
			end
			arp_pkg::ARP_CMP_DECR: begin
				if (result_valid) begin
					if (at_or_above) begin
						if (cnt_ff != 8'hff) nxt_cnt = cnt_ff + 8'h01;
					end else if (cnt_ff != 8'h00) begin
						nxt_cnt = cnt_ff - 8'h01; // floor at zero
					end
					nxt_hit = at_or_above && (nxt_cnt == count_limit);
				end
			end
			default: begin
				nxt_cnt = 8'h00;
			end
		endcase
	end

	// ==========================================================
	// registers
	// ==========================================================
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cnt_ff <= 8'h00;
			hit_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			hit_ff <= nxt_hit;
		end
	end

	assign count_value = cnt_ff;
	assign cmp_event   = hit_ff;

endmodule : arp_threshold

`default_nettype wire

/* arp_overrange.sv */
// coarse overrange detector with synchroniser and persistence filter
`default_nettype none

module arp_overrange #(
	parameter int PERSIST_CYC = arp_pkg::OVR_PERSIST_CYC // cycles the level must hold
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic enable,        // overrange enable bit
	input  wire logic coarse_over,   // raw coarse comparator, asynchronous
	output logic      over_event     // one-cycle pulse once persistence passed
);

	// ==========================================================
	// elaboration check
	// ==========================================================
	if (PERSIST_CYC < 1 || PERSIST_CYC > 1048575) begin : g_chk
		$error("arp_overrange: PERSIST_CYC out of range");
	end

	// ==========================================================
	// state
	// ==========================================================
	logic [2:0]  sync_ff;    // three stage synchroniser
	logic [2:0]  nxt_sync;
	logic        level_ff;   // filtered level, moves when stages 2 and 3 agree
	logic        nxt_level;
	logic [19:0] run_ff;     // cycles the level has stood high
	logic [19:0] nxt_run;
	logic        done_ff;    // event already given for this excursion
	logic        nxt_done;
	logic        evt_ff;
	logic        nxt_evt;

	// ==========================================================
	// next-state logic
	// ==========================================================
	// stage 1 feeds stage 2 only; filter looks at stages 2 and 3
	always_comb begin
		nxt_sync  = {sync_ff[1:0], coarse_over};
		nxt_level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : level_ff;
		nxt_run   = run_ff;
		nxt_done  = done_ff;
		nxt_evt   = 1'b0;
		if (!enable || !level_ff) begin
			// any break in the condition restarts the wait
			nxt_run  = 20'h00000;
			nxt_done = 1'b0;
		end else if (!done_ff) begin
			if (run_ff == 20'(PERSIST_CYC)) begin
				nxt_evt  = 1'b1; // held longer than the persistence time
				nxt_done = 1'b1;
			end else begin
				nxt_run = run_ff + 20'h00001;
			end
		end
	end

	// ==========================================================
	// registers
	// ==========================================================
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_ff  <= 3'h0;
			level_ff <= 1'b0;
			run_ff   <= 20'h00000;
			done_ff  <= 1'b0;
			evt_ff   <= 1'b0;
		end else begin
			sync_ff  <= nxt_sync;
			level_ff <= nxt_level;
			run_ff   <= nxt_run;
			done_ff  <= nxt_done;
			evt_ff   <= nxt_evt;
		end
	end

	assign over_event = evt_ff;

endmodule : arp_overrange

`default_nettype wire

/* arp_postprocess.sv */
// converter result post-processing: accumulator, comparator, counters, ground switch
//
// Implementation choice: strobed register access.
`default_nettype none

module arp_postprocess #(
	parameter int PERSIST_CYC = arp_pkg::OVR_PERSIST_CYC // overrange persistence cycles
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	// register port
	input  wire logic [31:0] reg_addr,          // byte address
	input  wire logic [31:0] reg_wdata,         // write data
	input  wire logic        reg_write,         // write strobe
	input  wire logic        reg_read,          // read strobe
	output logic      [31:0] reg_rdata,         // read data, cycle after strobe
	// converter side
	input  wire logic        result_valid,      // one-cycle completed conversion
	input  wire logic [23:0] result_data,       // conversion result
	input  wire logic        result_bipolar,    // result in two's complement
	input  wire logic        coarse_over,       // raw coarse overrange, asynchronous
	// outputs
	output logic             ground_connect,    // closes switched ground
	output logic             ground_resistor,   // inserts series resistor
	output logic             converter_irq      // one-cycle interrupt request
);

	// ==========================================================
	// elaboration check
	// ==========================================================
	// the persistence counter is 20 bits wide
	if (PERSIST_CYC < 1 || PERSIST_CYC > 1048575) begin : g_chk
		$error("arp_postprocess: PERSIST_CYC out of range");
	end

	// ==========================================================
	// software-visible registers
	// ==========================================================
	logic [7:0]         cfg_ff;      // extended configuration
	logic [7:0]         nxt_cfg;
	logic [15:0]        rc_lim_ff;   // result count limit
	logic [15:0]        nxt_rc_lim;
	logic [15:0]        rc_val_ff;   // result count value
	logic [15:0]        nxt_rc_val;
	logic [15:0]        thr_ff;      // comparator threshold
	logic [15:0]        nxt_thr;
	logic [7:0]         th_lim_ff;   // threshold count limit
	logic [7:0]         nxt_th_lim;
	logic signed [31:0] acc_ff;      // primary accumulator
	logic signed [31:0] nxt_acc;
	logic [7:0]         sta_ff;      // sticky status flags
	logic [7:0]         nxt_sta;
	logic [7:0]         msk_ff;      // interrupt mask
	logic [7:0]         nxt_msk;
	logic [31:0]        rd_ff;       // read data holding
	logic [31:0]        nxt_rd;
	logic               irq_ff;      // interrupt pulse
	logic               nxt_irq;
	logic               gnd_ff;      // ground switch drive
	logic               gres_ff;     // resistor drive

	// ==========================================================
	// decoded fields and helpers
	// ==========================================================
	logic [1:0]         acc_mode;    // accumulator mode field
	logic [1:0]         cmp_mode;    // comparator mode field
	logic [1:0]         cmp_eff;     // mode seen by the comparator
	logic signed [31:0] res_ext;     // result widened to 32 bits
	logic [23:0]        res_mag;     // absolute value
	logic               at_above;    // magnitude at or above threshold
	logic [7:0]         th_val;      // threshold count value
	logic               cmp_evt;     // comparator hit pulse
	logic               ovr_evt;     // overrange pulse
	logic               wr_cfg;      // write decode strobes
	logic               wr_sta;

	assign acc_mode = cfg_ff[arp_pkg::CFG_ACC_LO +: 2];
	assign cmp_mode = cfg_ff[arp_pkg::CFG_CMP_LO +: 2];
	assign wr_cfg   = reg_write && (reg_addr == arp_pkg::ADDR_EXT_CONFIG);
	assign wr_sta   = reg_write && (reg_addr == arp_pkg::ADDR_STATUS);

	// ==========================================================
	// result conditioning
	// ==========================================================
	// unipolar results are plain magnitudes; the top bit of a two's complement
	// result is its sign, so one threshold bit fewer takes part
	always_comb begin
		if (result_bipolar) begin
			res_ext  = {{8{result_data[23]}}, result_data};
			res_mag  = result_data[23] ? (24'h000000 - result_data) : result_data;
			// minus full scale leaves only bit 23 set
			at_above = res_mag[23] || (res_mag[22:8] >= thr_ff[14:0]);
		end else begin
			res_ext  = {8'h00, result_data};
			res_mag  = result_data;
			at_above = res_mag[23:8] >= thr_ff[15:0];
		end
	end

	// accumulate-plus-compare mode runs the comparator even when its own field
	// is off; in that case each result is checked on its own
	always_comb begin
		if (acc_mode == arp_pkg::ARP_ACC_CMP && cmp_mode == arp_pkg::ARP_CMP_OFF) begin
			cmp_eff = arp_pkg::ARP_CMP_PLAIN;
		end else begin
			cmp_eff = cmp_mode;
		end
	end

	// ==========================================================
	// comparator and overrange units
	// ==========================================================
	// both units register their events, so a comparator
	// interrupt trails the counter interrupt by one cycle
	arp_threshold u_threshold (
		.ref_clk      (ref_clk),
		.sys_rst      (sys_rst),
		.result_valid (result_valid),
		.at_or_above  (at_above),
		.cmp_mode     (cmp_eff),
		.count_limit  (th_lim_ff),
		.count_value  (th_val),
		.cmp_event    (cmp_evt)
	);

	arp_overrange #(
		.PERSIST_CYC (PERSIST_CYC)
	) u_overrange (
		.ref_clk     (ref_clk),
		.sys_rst     (sys_rst),
		.enable      (cfg_ff[arp_pkg::CFG_OVR_EN]),
		.coarse_over (coarse_over),
		.over_event  (ovr_evt)
	);

	// ==========================================================
	// accumulator
	// ==========================================================
	// outside the off mode, updates only on a result strobe, so one step per conversion
	// limitation: a long run wraps silently,
	// there is no overflow flag
	always_comb begin
		nxt_acc = acc_ff;
		case (arp_pkg::arp_acc_mode_t'(acc_mode))
			arp_pkg::ARP_ACC_OFF: begin
				nxt_acc = 32'sh00000000;
			end
			arp_pkg::ARP_ACC_FREE: begin
				// negative results carry their sign, so adding subtracts magnitude
				if (result_valid) nxt_acc = acc_ff + res_ext;
			end
			arp_pkg::ARP_ACC_CLAMP, arp_pkg::ARP_ACC_CMP: begin
				if (result_valid) begin
					nxt_acc = acc_ff + res_ext;
					// floor only for falling totals; positive wrap stays possible
					if (result_data[23] && result_bipolar && (nxt_acc < 0)) begin
						nxt_acc = 32'sh00000000;
					end
				end
			end
			default: begin
				nxt_acc = 32'sh00000000;
			end
		endcase
	end

	// ==========================================================
	// result counter and interrupt
	// ==========================================================
	// counter thins out conversion interrupts; comparator hits are gated by
	// the mask only in accumulate-plus-compare mode
	// a zero limit matches only when the count wraps past ffff,
	// so writing zero gives one interrupt per 65536 results
	always_comb begin
		nxt_rc_val = rc_val_ff;
		nxt_irq    = 1'b0;
		if (!cfg_ff[arp_pkg::CFG_RES_CNT_EN]) begin
			nxt_rc_val = 16'h0000;
			if (result_valid) nxt_irq = 1'b1;
		end else if (result_valid) begin
			if (rc_val_ff + 16'h0001 == rc_lim_ff) begin
				nxt_rc_val = 16'h0000; // restart after a match
				nxt_irq    = 1'b1;
			end else begin
				nxt_rc_val = rc_val_ff + 16'h0001;
			end
		end
		if (cmp_evt) begin
			if (acc_mode != arp_pkg::ARP_ACC_CMP || msk_ff[arp_pkg::MSK_COMPARE]) begin
				nxt_irq = 1'b1;
			end
		end
	end

	// ==========================================================
	// register writes and status
	// ==========================================================
	// status bits are write-one-to-clear; a new event wins over the clear
	// read-only registers have no write decode,
	// so writes to them vanish
	always_comb begin
		nxt_cfg    = cfg_ff;
		nxt_rc_lim = rc_lim_ff;
		nxt_thr    = thr_ff;
		nxt_th_lim = th_lim_ff;
		nxt_msk    = msk_ff;
		nxt_sta    = sta_ff;
		if (wr_cfg) nxt_cfg = reg_wdata[7:0];
		if (reg_write && reg_addr == arp_pkg::ADDR_COUNT_LIMIT) nxt_rc_lim = reg_wdata[15:0];
		if (reg_write && reg_addr == arp_pkg::ADDR_THRESHOLD) nxt_thr = reg_wdata[15:0];
		if (reg_write && reg_addr == arp_pkg::ADDR_TH_CNT_LIMIT) nxt_th_lim = reg_wdata[7:0];
		if (reg_write && reg_addr == arp_pkg::ADDR_MASK) nxt_msk = reg_wdata[7:0];
		if (wr_sta) nxt_sta = sta_ff & ~reg_wdata[7:0];
		if (cmp_evt) nxt_sta[arp_pkg::STA_THRESHOLD] = 1'b1;
		if (ovr_evt) nxt_sta[arp_pkg::STA_OVERRANGE] = 1'b1;
	end

	// ==========================================================
	// read mux
	// ==========================================================
	// unmapped addresses read as zero; data stand one cycle, then drop
	// registering costs a cycle but keeps the
	// address decode off the output path
	always_comb begin
		nxt_rd = 32'h00000000;
		if (reg_read) begin
			case (reg_addr)
				arp_pkg::ADDR_EXT_CONFIG:   nxt_rd = {24'h000000, cfg_ff};
				arp_pkg::ADDR_COUNT_LIMIT:  nxt_rd = {16'h0000, rc_lim_ff};
				arp_pkg::ADDR_COUNT_VALUE:  nxt_rd = {16'h0000, rc_val_ff};
				arp_pkg::ADDR_THRESHOLD:    nxt_rd = {16'h0000, thr_ff};
				arp_pkg::ADDR_TH_CNT_LIMIT: nxt_rd = {24'h000000, th_lim_ff};
				arp_pkg::ADDR_TH_CNT_VALUE: nxt_rd = {24'h000000, th_val};
				arp_pkg::ADDR_ACCUMULATOR:  nxt_rd = acc_ff;
				arp_pkg::ADDR_STATUS:       nxt_rd = {24'h000000, sta_ff};
				arp_pkg::ADDR_MASK:         nxt_rd = {24'h000000, msk_ff};
				default:                    nxt_rd = 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// registers
	// ==========================================================
	// reset opens the ground switch, so nothing
	// outside draws current until software asks
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cfg_ff    <= arp_pkg::RST_EXT_CONFIG;
			rc_lim_ff <= arp_pkg::RST_COUNT_LIMIT;
			rc_val_ff <= 16'h0000;
			thr_ff    <= arp_pkg::RST_THRESHOLD;
			th_lim_ff <= arp_pkg::RST_TH_LIMIT;
			acc_ff    <= 32'sh00000000;
			sta_ff    <= 8'h00;
			msk_ff    <= arp_pkg::RST_MASK;
			rd_ff     <= 32'h00000000;
			irq_ff    <= 1'b0;
			gnd_ff    <= 1'b0;
			gres_ff   <= 1'b0;
		end else begin
			cfg_ff    <= nxt_cfg;
			rc_lim_ff <= nxt_rc_lim;
			rc_val_ff <= nxt_rc_val;
			thr_ff    <= nxt_thr;
			th_lim_ff <= nxt_th_lim;
			acc_ff    <= nxt_acc;
			sta_ff    <= nxt_sta;
			msk_ff    <= nxt_msk;
			rd_ff     <= nxt_rd;
			irq_ff    <= nxt_irq;
			gnd_ff    <= nxt_cfg[arp_pkg::CFG_GND_EN];
			gres_ff   <= nxt_cfg[arp_pkg::CFG_GND_RES];
		end
	end

	// ==========================================================
	// outputs, all straight from flip-flops
	// ==========================================================
	assign reg_rdata       = rd_ff;
	assign converter_irq   = irq_ff;
	assign ground_connect  = gnd_ff;
	assign ground_resistor = gres_ff;

endmodule : arp_postprocess

`default_nettype wire

/* arp_postprocess_sva.sv */
// assertion checker for the result post-processing block
`default_nettype none

module arp_postprocess_sva #(
	parameter int PERSIST_CYC = arp_pkg::OVR_PERSIST_CYC // overrange persistence cycles
) (
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_write,
	input wire logic        reg_read,
	input wire logic [31:0] reg_rdata,
	input wire logic        result_valid,
	input wire logic [23:0] result_data,
	input wire logic        result_bipolar,
	input wire logic        coarse_over,
	input wire logic        ground_connect,
	input wire logic        ground_resistor,
	input wire logic        converter_irq
);
	// ==========================================================
	// config mirror, so irq checks know the active modes
	// ==========================================================
	logic       cfg_wr;  // write hits the config register
	logic [7:0] cfg_ff;  // config as last written
	logic [7:0] nxt_cfg; // next config mirror
	assign cfg_wr = reg_write && reg_addr == arp_pkg::ADDR_EXT_CONFIG;
	// next value of the mirror
	always_comb begin
		nxt_cfg = cfg_wr ? reg_wdata[7:0] : cfg_ff;
	end
	// register the mirror
	always_ff @(posedge ref_clk) begin
		cfg_ff <= sys_rst ? 8'h00 : nxt_cfg;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// assertions
	// ==========================================================
	chk_gnd_follow: assert property (cfg_wr |=> ground_connect == $past(reg_wdata[7]))
		else $error("ground switch does not follow config");
	chk_res_follow: assert property (cfg_wr |=> ground_resistor == $past(reg_wdata[1]))
		else $error("resistor select does not follow config");
	chk_pins_hold: assert property (!cfg_wr |=> $stable({ground_connect, ground_resistor}))
		else $error("ground outputs moved without a write");
	chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	chk_cfg_readback: assert property (reg_read && reg_addr == arp_pkg::ADDR_EXT_CONFIG |=>
		reg_rdata == {24'h0, cfg_ff})
		else $error("config read back wrong");
	chk_unmapped_zero: assert property (reg_read && (reg_addr[31:12] != 20'hffff0 ||
		reg_addr[11:0] > 12'h550) |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_irq_every: assert property (result_valid && !cfg_ff[0] |=> converter_irq)
		else $error("no interrupt after conversion");
	chk_irq_cause: assert property (converter_irq && cfg_ff[4:2] == 3'h0 && cfg_ff[6:5] != 2'h3
		|-> $past(result_valid))
		else $error("interrupt without a result");
endmodule : arp_postprocess_sva

bind arp_postprocess arp_postprocess_sva #(.PERSIST_CYC(PERSIST_CYC)) u_sva (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
	.result_valid(result_valid), .result_data(result_data), .result_bipolar(result_bipolar),
	.coarse_over(coarse_over), .ground_connect(ground_connect),
	.ground_resistor(ground_resistor), .converter_irq(converter_irq)
);

`default_nettype wire

/* arp_postprocess_tb.sv */
// self-checking bench for the result post-processing block
`default_nettype none

module arp_postprocess_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// stimulus and observed signals
	// ==========================================================
	logic        ref_clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
	logic        result_valid = 1'b0, result_bipolar = 1'b1, coarse_over = 1'b0;
	logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata;
	logic [23:0] result_data = 24'h0;
	logic        ground_connect, ground_resistor, converter_irq;
	int          failures = 0, total_checks = 0, cycles = 0;
	localparam logic [23:0] HI = 24'h000200; // magnitude equals threshold 2
	localparam logic [23:0] NG = 24'hfffe00; // negative, same magnitude
	localparam logic [23:0] LO = 24'h0001ff; // just below threshold
	arp_postprocess #(.PERSIST_CYC(20)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .result_valid(result_valid), .result_data(result_data),
		.result_bipolar(result_bipolar), .coarse_over(coarse_over),
		.ground_connect(ground_connect), .ground_resistor(ground_resistor),
		.converter_irq(converter_irq));
	always #5 ref_clk = ~ref_clk;
	// hang guard, far above the expected run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			end_sim();
		end
	end
	// ==========================================================
	// shared tasks
	// ==========================================================
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// one write strobe, map offset only
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_write <= 1'b1;
		reg_addr  <= {20'hffff0, a};
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_write <= 1'b0;
		#1;
	endtask : wr
	// read strobe, data judged in the answer cycle only
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_read <= 1'b1;
		reg_addr <= {20'hffff0, a};
		@(posedge ref_clk);
		reg_read <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd
	// one result, then count irq pulses over three cycles
	task automatic rs(input logic [23:0] d, input logic [31:0] n);
		logic [31:0] k;
		k = 32'h0;
		@(posedge ref_clk);
		result_valid <= 1'b1;
		result_data  <= d;
		@(posedge ref_clk);
		result_valid <= 1'b0;
		repeat (3) begin
			#1;
			if (converter_irq === 1'b1) k++;
			@(posedge ref_clk);
		end
		chk(k, n);
	endtask : rs
	// coarse level held n cycles, then settle
	task automatic ov(input int n);
		@(posedge ref_clk);
		coarse_over <= 1'b1;
		repeat (n) @(posedge ref_clk);
		coarse_over <= 1'b0;
		repeat (8) @(posedge ref_clk);
	endtask : ov
	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_regs;
		rd(12'h518, 32'h0);
		rd(12'h534, 32'h1);
		rd(12'h548, 32'h0);
		rd(12'h600, 32'h0);
		wr(12'h518, 32'h82);
		chk({30'h0, ground_connect, ground_resistor}, 32'h3);
		rd(12'h518, 32'h82);
		wr(12'h518, 32'h80);
		chk({30'h0, ground_connect, ground_resistor}, 32'h2);
		wr(12'h518, 32'h0);
		chk({30'h0, ground_connect, ground_resistor}, 32'h0);
	endtask : t_regs
	task automatic t_count;
		rs(LO, 32'h1);
		wr(12'h534, 32'h2);
		wr(12'h518, 32'h1);
		rs(LO, 32'h0);
		rd(12'h538, 32'h1);
		rs(LO, 32'h1);
		rd(12'h538, 32'h0);
		wr(12'h534, 32'h0);  // limit zero leaves one counter interrupt per 65536 results
	endtask : t_count
	task automatic t_acc;
		wr(12'h518, 32'h21);
		rs(24'h000005, 32'h0);
		rd(12'h548, 32'h5);
		rs(24'hfffff8, 32'h0);
		rd(12'h548, 32'h0);
		wr(12'h518, 32'h1);
		rs(LO, 32'h0);       // two conversions off before re-enable
		rs(LO, 32'h0);
		wr(12'h518, 32'h41);
		rs(24'h000005, 32'h0);
		rs(24'hfffff8, 32'h0);
		rd(12'h548, 32'hfffffffd);
		wr(12'h518, 32'h1);
		rs(LO, 32'h0);
		rs(LO, 32'h0);
		rd(12'h548, 32'h0);
	endtask : t_acc
	task automatic t_cmp;
		wr(12'h53c, 32'h2);
		wr(12'h518, 32'h9);
		rs(HI, 32'h1);
		rs(NG, 32'h1);
		rs(LO, 32'h0);
		wr(12'h53c, 32'h8002);
		rs(HI, 32'h1);
		result_bipolar <= 1'b0;
		rs(HI, 32'h0);
		rs(24'h800200, 32'h1);
		result_bipolar <= 1'b1;
		wr(12'h53c, 32'h2);
		wr(12'h518, 32'h1);
		rs(HI, 32'h0);
		wr(12'h54c, 32'h8);
		wr(12'h540, 32'h2);
		wr(12'h518, 32'h11);
		rs(HI, 32'h0);
		rs(LO, 32'h0);
		rs(HI, 32'h0);
		rd(12'h544, 32'h1);
		rs(HI, 32'h1);
		rd(12'h54c, 32'h8);
		wr(12'h54c, 32'h8);
		rd(12'h54c, 32'h0);
		wr(12'h518, 32'h1);
		wr(12'h540, 32'h3);
		wr(12'h518, 32'h19);
		rs(HI, 32'h0);
		rs(HI, 32'h0);
		rs(LO, 32'h0);
		rd(12'h544, 32'h1);
		rs(HI, 32'h0);
		rs(HI, 32'h1);
		wr(12'h518, 32'h61);
		rs(HI, 32'h0);
		wr(12'h550, 32'h40);
		rs(HI, 32'h1);
		wr(12'h518, 32'h1);
		wr(12'h54c, 32'hff);
	endtask : t_cmp
	task automatic t_ovr;
		ov(40);
		rd(12'h54c, 32'h0);
		wr(12'h518, 32'h5);  // overrange enable, result counter on
		ov(10);
		rd(12'h54c, 32'h0);
		ov(40);
		rd(12'h54c, 32'h10);
	endtask : t_ovr
	// closing report, the one exit
	task automatic end_sim;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	initial begin
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		t_regs();
		t_count();
		t_acc();
		t_cmp();
		t_ovr();
		end_sim();
	end
endmodule : arp_postprocess_tb

`default_nettype wire
